// ===== include/osd_pkg.sv
// package: constants and carriers for the output delay and relay polarity block
package osd_pkg;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_HZ = 25000000;          // MCLK rate
   localparam int TENTH_S_NS = 100000000;     // one delay step, 0.1 s, in ns
   localparam int CLK_PERIOD_NS = 40;         // MCLK period in ns
   localparam int TICK_CYCLES_DFLT = TENTH_S_NS / CLK_PERIOD_NS; // cycles per 0.1 s step
   localparam int DLY_W = 10;                 // delay field width, tenths of a second
   localparam logic [DLY_W-1:0] DLY_MAX = 10'h3e8; // 100.0 s in tenths
   localparam logic [DLY_W-1:0] DLY_RST = 10'h000; // 0.0 s default
   // ------------------------------------------------------------
   // function codes
   // ------------------------------------------------------------
   localparam int FN_W = 4;                   // function select width
   localparam int FN_NUM = 9;                 // selectable functions
   localparam logic [FN_W-1:0] FN_RUN = 4'h0;   // run indication
   localparam logic [FN_W-1:0] FN_ALARM = 4'h5; // alarm, relay default
   localparam logic RELAY_POL_NORM_OPEN = 1'b0;   // coil off while signal off
   localparam logic RELAY_POL_NORM_CLOSED = 1'b1; // coil on while signal off
   localparam logic RELAY_POL_RST = RELAY_POL_NORM_CLOSED;
   localparam int NOUT = 3;                   // terminal 11, terminal 12, relay
   localparam int IDX_A = 0;
   localparam int IDX_B = 1;
   localparam int IDX_RLY = 2;
   // per-output delay pair
   typedef struct packed {
      logic [DLY_W-1:0] on_dly;   // off-to-on delay, tenths
      logic [DLY_W-1:0] off_dly;  // on-to-off delay, tenths
   } osd_dly_t;
   // delay timer state
   typedef enum logic [1:0] {
      ST_OFF = 2'b00,
      ST_ON_WAIT = 2'b01,
      ST_ON = 2'b10,
      ST_OFF_WAIT = 2'b11
   } osd_state_t;
endpackage

// ===== logic/osd_top.sv
// output signal on/off delays, relay source select and coil polarity
`timescale 1ns/10ps
//
// Contract
// - relay source: any of nine functions, alarm default
// - polarity 0 coil off, 1 coil on when off
// - polarity defaults to coil energized when off
// - source code zero routes run indication
// - alarm assignable to terminal 11 or 12
// - each output has own on and off delay
// - delays in 0.1 s steps, max 100.0 s
// - six delays default 0.0, zero passes through
// - output asserts after source on for delay
// - output drops after source off for delay
// - both delays: leading and trailing edges delayed
// - delays apply whatever function is assigned
// - run indication follows run versus stop mode
// - open collector terminals are active low
module osd_top #(
   parameter int TICK_CYCLES = osd_pkg::TICK_CYCLES_DFLT  // cycles per 0.1 s step
) (
   input wire logic MCLK,
   input wire logic RESET_N,
   input wire logic [osd_pkg::FN_NUM-1:0] FUNC_IN,   // function signals, bit 0 from RUN_MODE
   input wire logic RUN_MODE,                         // drive in run mode
   input wire logic [osd_pkg::FN_W-1:0] OUT_A_FUNC_SEL,
   input wire logic [osd_pkg::FN_W-1:0] OUT_B_FUNC_SEL,
   input wire logic [osd_pkg::FN_W-1:0] RELAY_SOURCE_SELECT,
   input wire logic RELAY_COIL_POLARITY,
   input wire logic LOAD_DEFAULTS,                    // restore default settings
   input wire logic CFG_WE,                           // load selects and delays
   input wire osd_pkg::osd_dly_t OUT_A_DLY,
   input wire osd_pkg::osd_dly_t OUT_B_DLY,
   input wire osd_pkg::osd_dly_t RELAY_DLY,
   output logic OUT_A_N,            // terminal 11, low pulls to ground
   output logic OUT_B_N,            // terminal 12, low pulls to ground
   output logic RELAY_COIL,         // coil energized
   output logic [osd_pkg::NOUT-1:0] OUT_STATE  // delayed signals, before polarity
);
   import osd_pkg::*;

   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   logic [1:0] rst_sync_r;  // two-stage release
   logic rst_n;             // synchronised reset
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rst_sync_r <= 2'b00;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   logic [FN_W-1:0] sel_r [NOUT];   // function select per output
   logic [FN_W-1:0] sel_nxt [NOUT];
   osd_dly_t dly_r [NOUT];          // delay pair per output
   osd_dly_t dly_nxt [NOUT];
   logic pol_r;                     // relay coil polarity
   logic pol_nxt;
   osd_dly_t dly_in [NOUT];
   logic [FN_W-1:0] sel_in [NOUT];
   assign dly_in[IDX_A] = OUT_A_DLY;
   assign dly_in[IDX_B] = OUT_B_DLY;
   assign dly_in[IDX_RLY] = RELAY_DLY;
   assign sel_in[IDX_A] = OUT_A_FUNC_SEL;
   assign sel_in[IDX_B] = OUT_B_FUNC_SEL;
   assign sel_in[IDX_RLY] = RELAY_SOURCE_SELECT;

   // clamp a delay to 100.0 s; values above the range are not accepted as such
   function automatic logic [DLY_W-1:0] clamp_dly(input logic [DLY_W-1:0] d);
      clamp_dly = (d > DLY_MAX) ? DLY_MAX : d;
   endfunction

   // next configuration; defaults give relay alarm and zero delays
   always_comb begin
      pol_nxt = pol_r;
      for (int i = 0; i < NOUT; i++) begin
         sel_nxt[i] = sel_r[i];
         dly_nxt[i] = dly_r[i];
         if (LOAD_DEFAULTS) begin
            sel_nxt[i] = (i == IDX_RLY) ? FN_ALARM : FN_RUN;
            dly_nxt[i] = '{on_dly: DLY_RST, off_dly: DLY_RST};
         end else if (CFG_WE) begin
            // out-of-range codes are ignored, any of nine accepted
            if (sel_in[i] < FN_W'(FN_NUM)) begin
               sel_nxt[i] = sel_in[i];
            end
            dly_nxt[i].on_dly = clamp_dly(dly_in[i].on_dly);
            dly_nxt[i].off_dly = clamp_dly(dly_in[i].off_dly);
         end
      end
      if (LOAD_DEFAULTS) begin
         pol_nxt = RELAY_POL_RST;
      end else if (CFG_WE) begin
         pol_nxt = RELAY_COIL_POLARITY;
      end
   end

   // register configuration
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         pol_r <= RELAY_POL_RST;
         for (int i = 0; i < NOUT; i++) begin
            sel_r[i] <= (i == IDX_RLY) ? FN_ALARM : FN_RUN;
            dly_r[i] <= '{on_dly: DLY_RST, off_dly: DLY_RST};
         end
      end else begin
         pol_r <= pol_nxt;
         for (int i = 0; i < NOUT; i++) begin
            sel_r[i] <= sel_nxt[i];
            dly_r[i] <= dly_nxt[i];
         end
      end
   end

   // ------------------------------------------------------------
   // 0.1 s step divider
   // ------------------------------------------------------------
   logic [31:0] div_r;   // divider count
   logic [31:0] div_nxt;
   logic tick;           // one-cycle pulse each 0.1 s
   assign tick = (div_r == 32'(TICK_CYCLES - 1));
   always_comb begin
      div_nxt = tick ? 32'h0 : div_r + 32'h1;
   end
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         div_r <= 32'h0;
      end else begin
         div_r <= div_nxt;
      end
   end

   // ------------------------------------------------------------
   // function inputs: run from mode, all synchronised
   // ------------------------------------------------------------
   // functions come from elsewhere in the drive; sync keeps them glitch free
   logic [FN_NUM-1:0] fs1_r, fs2_r, fs3_r;  // three-stage chains
   logic [FN_NUM-1:0] fn_r, fn_nxt;         // accepted function levels
   logic [FN_NUM-1:0] fn_raw;
   assign fn_raw = {FUNC_IN[FN_NUM-1:1], RUN_MODE};
   always_comb begin
      for (int i = 0; i < FN_NUM; i++) begin
         fn_nxt[i] = (fs2_r[i] == fs3_r[i]) ? fs3_r[i] : fn_r[i];
      end
   end
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         fs1_r <= '0;
         fs2_r <= '0;
         fs3_r <= '0;
         fn_r <= '0;
      end else begin
         fs1_r <= fn_raw;
         fs2_r <= fs1_r;
         fs3_r <= fs2_r;
         fn_r <= fn_nxt;
      end
   end

   // ------------------------------------------------------------
   // per-output delay timers
   // ------------------------------------------------------------
   logic [NOUT-1:0] src;      // selected source per output
   logic [NOUT-1:0] dout_r;   // delayed output level
   genvar g;
   generate
      for (g = 0; g < NOUT; g++) begin : g_out
         osd_state_t st_r, st_nxt;           // timer state
         logic [DLY_W-1:0] cnt_r, cnt_nxt;   // elapsed tenths
         logic q_nxt;
         // any function may feed any output, delays apply regardless
         assign src[g] = fn_r[sel_r[g]];
         always_comb begin
            st_nxt = st_r;
            cnt_nxt = cnt_r;
            q_nxt = dout_r[g];
            case (st_r)
               ST_OFF: begin
                  if (src[g]) begin
                     if (dly_r[g].on_dly == DLY_RST) begin
                        st_nxt = ST_ON;
                        q_nxt = 1'b1;
                     end else begin
                        st_nxt = ST_ON_WAIT;
                        cnt_nxt = '0;
                     end
                  end
               end
               ST_ON_WAIT: begin
                  if (!src[g]) begin
                     st_nxt = ST_OFF;
                     cnt_nxt = '0;
                  end else if (tick) begin
                     if (cnt_r + 10'h1 >= dly_r[g].on_dly) begin
                        st_nxt = ST_ON;
                        q_nxt = 1'b1;
                     end else begin
                        cnt_nxt = cnt_r + 10'h1;
                     end
                  end
               end
               ST_ON: begin
                  if (!src[g]) begin
                     if (dly_r[g].off_dly == DLY_RST) begin
                        st_nxt = ST_OFF;
                        q_nxt = 1'b0;
                     end else begin
                        st_nxt = ST_OFF_WAIT;
                        cnt_nxt = '0;
                     end
                  end
               end
               ST_OFF_WAIT: begin
                  if (src[g]) begin
                     st_nxt = ST_ON;
                     cnt_nxt = '0;
                  end else if (tick) begin
                     if (cnt_r + 10'h1 >= dly_r[g].off_dly) begin
                        st_nxt = ST_OFF;
                        q_nxt = 1'b0;
                     end else begin
                        cnt_nxt = cnt_r + 10'h1;
                     end
                  end
               end
               default: begin
                  st_nxt = ST_OFF;
                  q_nxt = 1'b0;
               end
            endcase
         end
         always_ff @(posedge MCLK or negedge rst_n) begin
            if (!rst_n) begin
               st_r <= ST_OFF;
               cnt_r <= '0;
               dout_r[g] <= 1'b0;
            end else begin
               st_r <= st_nxt;
               cnt_r <= cnt_nxt;
               dout_r[g] <= q_nxt;
            end
         end
         // a waiting timer moves the output only on the tick that ends it, never on a revert
         property p_hold_while_wait;
            @(posedge MCLK) disable iff (!rst_n)
            ((st_r == ST_ON_WAIT) && (!src[g] || !tick))
            || ((st_r == ST_OFF_WAIT) && (src[g] || !tick)) |=> $stable(dout_r[g]);
         endproperty
         a_hold_while_wait: assert property (p_hold_while_wait)
            else $error("output moved while a delay was pending");
      end
   endgenerate

   // ------------------------------------------------------------
   // pins
   // ------------------------------------------------------------
   // coil level: signal xor polarity; polarity 1 energizes while signal off
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         OUT_A_N <= 1'b1;
         OUT_B_N <= 1'b1;
         RELAY_COIL <= RELAY_POL_RST;
         OUT_STATE <= '0;
      end else begin
         OUT_A_N <= ~dout_r[IDX_A];
         OUT_B_N <= ~dout_r[IDX_B];
         RELAY_COIL <= dout_r[IDX_RLY] ^ pol_r;
         OUT_STATE <= dout_r;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_pin_low_active;
      @(posedge MCLK) disable iff (!rst_n)
      1'b1 |=> (OUT_A_N == ~$past(dout_r[IDX_A]));
   endproperty
   a_pin_low_active: assert property (p_pin_low_active)
      else $error("terminal 11 not active low");

   property p_coil_pol;
      @(posedge MCLK) disable iff (!rst_n)
      1'b1 |=> (RELAY_COIL == ($past(dout_r[IDX_RLY]) ^ $past(pol_r)));
   endproperty
   a_coil_pol: assert property (p_coil_pol)
      else $error("relay coil level wrong for polarity");

   property p_defaults;
      @(posedge MCLK) disable iff (!rst_n)
      LOAD_DEFAULTS |=> (sel_r[IDX_RLY] == FN_ALARM && pol_r == RELAY_POL_NORM_CLOSED
                         && dly_r[IDX_RLY].on_dly == DLY_RST);
   endproperty
   a_defaults: assert property (p_defaults)
      else $error("defaults not restored");

   property p_dly_range;
      @(posedge MCLK) disable iff (!rst_n)
      dly_r[IDX_A].on_dly <= DLY_MAX && dly_r[IDX_B].off_dly <= DLY_MAX;
   endproperty
   a_dly_range: assert property (p_dly_range)
      else $error("delay above 100.0 s");

   property p_zero_pass;
      @(posedge MCLK) disable iff (!rst_n)
      (dly_r[IDX_A].on_dly == DLY_RST && src[IDX_A] && !dout_r[IDX_A]
       && g_out[IDX_A].st_r == ST_OFF
       && !LOAD_DEFAULTS && !CFG_WE) |=> dout_r[IDX_A];
   endproperty
   a_zero_pass: assert property (p_zero_pass)
      else $error("zero on delay did not pass through");

   property p_on_needs_src;
      @(posedge MCLK) disable iff (!rst_n)
      $rose(dout_r[IDX_B]) |-> $past(src[IDX_B]);
   endproperty
   a_on_needs_src: assert property (p_on_needs_src)
      else $error("output rose without source on");

   property p_off_needs_src;
      @(posedge MCLK) disable iff (!rst_n)
      $fell(dout_r[IDX_RLY]) |-> !$past(src[IDX_RLY]);
   endproperty
   a_off_needs_src: assert property (p_off_needs_src)
      else $error("output fell while source on");

   property p_run_route;
      @(posedge MCLK) disable iff (!rst_n)
      (sel_r[IDX_RLY] == FN_RUN) |-> (src[IDX_RLY] == fn_r[0]);
   endproperty
   a_run_route: assert property (p_run_route)
      else $error("run not routed to relay");
endmodule

// ===== tb/osd_load_model.sv
// external load model: pulled-up open-collector inputs and form c relay contacts
`timescale 1ns/10ps
module osd_load_model (
   input wire logic out_a_n,        // terminal 11 transistor, low conducts
   input wire logic out_b_n,        // terminal 12 transistor, low conducts
   input wire logic relay_coil,     // coil energized
   output logic term_a_lvl,         // level seen by the load on terminal 11
   output logic term_b_lvl,         // level seen by the load on terminal 12
   output logic make_closed,        // common to make contact closed
   output logic break_closed        // common to break contact closed
);
   // the pull-up wins whenever the transistor is released
   assign term_a_lvl = (out_a_n === 1'b0) ? 1'b0 : 1'b1;
   assign term_b_lvl = (out_b_n === 1'b0) ? 1'b0 : 1'b1;
   // the contacts follow the coil, never the signal itself
   assign make_closed = (relay_coil === 1'b1);
   assign break_closed = (relay_coil !== 1'b1);
endmodule

// ===== tb/osd_tb_top.sv
// testbench: drives the output delay block and compares it with a behavioural model
`timescale 1ns/10ps
module osd_tb_top;
   import osd_pkg::*;
   localparam int TK = 4;  // short tick keeps 100 s delays inside the run
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic [FN_NUM-1:0] func_in = '0;
   logic run_mode = 1'b0;
   logic [FN_W-1:0] sel_a = FN_RUN;
   logic [FN_W-1:0] sel_b = FN_RUN;
   logic [FN_W-1:0] sel_r = FN_ALARM;
   logic pol = 1'b1;
   logic load_dflt = 1'b0;
   logic cfg_we = 1'b0;
   osd_dly_t dly_a = '0;
   osd_dly_t dly_b = '0;
   osd_dly_t dly_r = '0;
   logic out_a_n, out_b_n, relay_coil;
   logic [NOUT-1:0] out_state;
   logic lvl_a, lvl_b, make_c, break_c;
   int error_cnt = 0;
   int total_checks = 0;
   always #20 mclk = ~mclk;
   osd_top #(.TICK_CYCLES(TK)) osd_top_inst (
      .MCLK(mclk), .RESET_N(reset_n), .FUNC_IN(func_in), .RUN_MODE(run_mode),
      .OUT_A_FUNC_SEL(sel_a), .OUT_B_FUNC_SEL(sel_b), .RELAY_SOURCE_SELECT(sel_r),
      .RELAY_COIL_POLARITY(pol), .LOAD_DEFAULTS(load_dflt), .CFG_WE(cfg_we),
      .OUT_A_DLY(dly_a), .OUT_B_DLY(dly_b), .RELAY_DLY(dly_r),
      .OUT_A_N(out_a_n), .OUT_B_N(out_b_n), .RELAY_COIL(relay_coil), .OUT_STATE(out_state)
   );
   osd_load_model osd_load_model_inst (
      .out_a_n(out_a_n), .out_b_n(out_b_n), .relay_coil(relay_coil),
      .term_a_lvl(lvl_a), .term_b_lvl(lvl_b), .make_closed(make_c), .break_closed(break_c)
   );
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic results();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // inputs always move 1 ns after the rising edge
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic cfg();
      cfg_we = 1'b1;
      cyc(1);
      cfg_we = 1'b0;
   endtask
   // model of the source selection: code zero is the run indication
   function automatic logic src(input logic [FN_W-1:0] c);
      return (c == FN_RUN) ? run_mode : func_in[c];
   endfunction
   // zero delays: everything settles well inside ten cycles
   task automatic chk_all();
      logic ea, eb, er;
      cyc(10);
      ea = src(sel_a);
      eb = src(sel_b);
      er = src(sel_r);
      chk("out_state", out_state, {er, eb, ea});
      chk("out_a_n", out_a_n, !ea);
      chk("out_b_n", out_b_n, !eb);
      chk("term_a", lvl_a, !ea);
      chk("term_b", lvl_b, !eb);
      chk("relay_coil", relay_coil, er ^ pol);
      chk("make", make_c, er ^ pol);
      chk("break", break_c, !(er ^ pol));
   endtask
   // bounded wait for an output edge; too early or never both count as mismatches
   task automatic wait_bit(input int idx, input logic val, input int lo, input int hi);
      int n;
      n = 0;
      while (out_state[idx] !== val && n < hi) begin
         cyc(1);
         n++;
      end
      chk("edge_seen", out_state[idx], val);
      if (out_state[idx] !== val) results();
      chk("edge_late_enough", n >= lo, 1'b1);
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      void'($urandom(70082));
      cyc(3);
      chk("rst_coil", relay_coil, 1'b1);
      chk("rst_state", out_state, 3'h0);
      cyc(3);
      reset_n = 1'b1;
      cyc(4);
      func_in[FN_ALARM] = 1'b1;
      chk_all();
      // every relay source code, random levels and other selects
      for (int c = 0; c < FN_NUM; c++) begin
         repeat (2) begin
            func_in = 9'($urandom);
            run_mode = 1'($urandom);
            sel_a = 4'($urandom % FN_NUM);
            sel_b = 4'($urandom % FN_NUM);
            pol = 1'($urandom);
            sel_r = 4'(c);
            cfg();
            chk_all();
         end
      end
      // out of range code must leave the relay source alone
      sel_r = 4'hf;
      cfg();
      sel_r = 4'(FN_NUM - 1);
      chk_all();
      // alarm on terminals while the relay shows run mode
      sel_a = FN_ALARM;
      sel_b = FN_ALARM;
      sel_r = FN_RUN;
      cfg();
      run_mode = 1'b1;
      chk_all();
      run_mode = 1'b0;
      chk_all();
      // delays: a on only, b off only, relay both, all on the alarm
      func_in = '0;
      sel_r = FN_ALARM;
      pol = 1'b0;
      dly_a = '{on_dly: 10'h003, off_dly: 10'h000};
      dly_b = '{on_dly: 10'h000, off_dly: 10'h003};
      dly_r = '{on_dly: 10'h002, off_dly: 10'h003};
      cfg();
      cyc(20);
      func_in[FN_ALARM] = 1'b1;
      cyc(4);
      func_in[FN_ALARM] = 1'b0;
      cyc(4);
      chk("b_stretched", out_state[IDX_B], 1'b1);
      cyc(30);
      chk("short_pulse", out_state, 3'h0);
      // a two cycle drop gets through the input filter and restarts the on timers;
      // a timer that kept counting would fire before 3 * TK
      func_in[FN_ALARM] = 1'b1;
      cyc(6);
      func_in[FN_ALARM] = 1'b0;
      cyc(2);
      func_in[FN_ALARM] = 1'b1;
      wait_bit(IDX_A, 1'b1, 3 * TK, 4 * TK + 10);
      wait_bit(IDX_RLY, 1'b1, 0, 20);
      // short gap is bridged by the off delays
      func_in[FN_ALARM] = 1'b0;
      cyc(2);
      func_in[FN_ALARM] = 1'b1;
      cyc(20);
      chk("gap_b", out_state[IDX_B], 1'b1);
      chk("gap_coil", relay_coil, 1'b1);
      func_in[FN_ALARM] = 1'b0;
      wait_bit(IDX_B, 1'b0, 2 * TK, 3 * TK + 10);
      chk("a_no_off_delay", out_state[IDX_A], 1'b0);
      wait_bit(IDX_RLY, 1'b0, 0, 20);
      // oversized on delay is held at 100.0 s
      dly_a = '{on_dly: 10'h3ff, off_dly: 10'h000};
      cfg();
      func_in[FN_ALARM] = 1'b1;
      wait_bit(IDX_A, 1'b1, 999 * TK, 1000 * TK + 10);
      // restore defaults and check the port model against them
      load_dflt = 1'b1;
      cyc(1);
      load_dflt = 1'b0;
      sel_a = FN_RUN;
      sel_b = FN_RUN;
      sel_r = FN_ALARM;
      pol = 1'b1;
      dly_a = '0;
      dly_b = '0;
      dly_r = '0;
      func_in[FN_ALARM] = 1'b0;
      chk_all();
      results();
   end
endmodule
